/* rtl/edge_wakeup_pkg.sv */
// Constants for the edge event and wakeup controller.
// Assumes a 32-bit plain register port with byte addresses.
package edge_wakeup_pkg;

  // Line counts and the split between external and internal lines.
  localparam int LINE_COUNT = 44;
  localparam int EXT_COUNT  = 16;
  localparam int INT_COUNT  = 28;
  localparam int PIN_COUNT  = 107;
  localparam int SEL_W      = 7;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int HI_W       = LINE_COUNT - DATA_W;

  // Register byte offsets.
  localparam logic [7:0] OFF_IRQ_EN_LO = 8'h00;
  localparam logic [7:0] OFF_IRQ_EN_HI = 8'h04;
  localparam logic [7:0] OFF_EVT_EN_LO = 8'h08;
  localparam logic [7:0] OFF_EVT_EN_HI = 8'h0c;
  localparam logic [7:0] OFF_RISE_EN   = 8'h10;
  localparam logic [7:0] OFF_FALL_EN   = 8'h14;
  localparam logic [7:0] OFF_PEND_LO   = 8'h18;
  localparam logic [7:0] OFF_PEND_HI   = 8'h1c;
  localparam logic [7:0] OFF_CLR_LO    = 8'h20;
  localparam logic [7:0] OFF_CLR_HI    = 8'h24;
  localparam logic [7:0] OFF_SEL0      = 8'h30;
  localparam int         SEL_WORDS     = 4;
  localparam int         SEL_PER_WORD  = 4;
  localparam int         SEL_LANE      = 8;

  // Values after reset.
  localparam logic [LINE_COUNT-1:0] RST_IRQ_EN = 44'h000_0000_0000;
  localparam logic [LINE_COUNT-1:0] RST_EVT_EN = 44'h000_0000_0000;
  localparam logic [EXT_COUNT-1:0]  RST_EDGE   = 16'h0000;
  localparam logic [SEL_W-1:0]      RST_SEL    = 7'h00;

endpackage

/* rtl/edge_event_wakeup_controller.sv */
// Edge event and wakeup controller: 16 pin-fed edge lines and 28 peripheral lines.
// Assumes one system clock, a plain register port and pin inputs from outside the clock domain.
// Operation
// - 44 lines giving interrupt or event requests
// - Enabled edge wakes system from Stop mode
// - Per external line rising, falling or both
// - Independent per-line mask blocks its request
// - Readable pending bit records each unmasked interrupt request
// - Pulses shorter than a clock are caught on external lines
// - 107 pins selectable onto 16 external lines
// - Internal lines driven by wakeup-capable peripherals
`timescale 1ns/1ps

module edge_event_wakeup_controller
  import edge_wakeup_pkg::*;
(
  input  wire logic                                  sys_clk,
  input  wire logic                                  sys_rst,
  input  wire logic [edge_wakeup_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [edge_wakeup_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [edge_wakeup_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [edge_wakeup_pkg::PIN_COUNT-1:0] gpio_in,
  input  wire logic [edge_wakeup_pkg::INT_COUNT-1:0] periph_wake_in,
  input  wire logic                                  stop_mode,
  output logic      [edge_wakeup_pkg::LINE_COUNT-1:0] line_irq,
  output logic                                       irq,
  output logic                                       evt_req,
  output logic                                       wakeup_req
);
  import edge_wakeup_pkg::*;

  logic [LINE_COUNT-1:0] irq_en;
  logic [LINE_COUNT-1:0] evt_en;
  logic [EXT_COUNT-1:0]  rise_en;
  logic [EXT_COUNT-1:0]  fall_en;
  logic [LINE_COUNT-1:0] pend;
  logic [LINE_COUNT-1:0] clr_vec;
  logic [LINE_COUNT-1:0] hit;
  logic [LINE_COUNT-1:0] next_pend;
  logic [SEL_W-1:0]      sel [EXT_COUNT];
  logic [EXT_COUNT-1:0]  pin_sel;
  logic [EXT_COUNT-1:0]  rise_hit;
  logic [EXT_COUNT-1:0]  fall_hit;
  logic [INT_COUNT-1:0]  periph_q;

  // Configuration writes; each register sits at its own aligned word.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_en  <= RST_IRQ_EN;
      evt_en  <= RST_EVT_EN;
      rise_en <= RST_EDGE;
      fall_en <= RST_EDGE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFF_IRQ_EN_LO: irq_en[DATA_W-1:0]          <= reg_wdata;
        OFF_IRQ_EN_HI: irq_en[LINE_COUNT-1:DATA_W] <= reg_wdata[HI_W-1:0];
        OFF_EVT_EN_LO: evt_en[DATA_W-1:0]          <= reg_wdata;
        OFF_EVT_EN_HI: evt_en[LINE_COUNT-1:DATA_W] <= reg_wdata[HI_W-1:0];
        OFF_RISE_EN:   rise_en                     <= reg_wdata[EXT_COUNT-1:0];
        OFF_FALL_EN:   fall_en                     <= reg_wdata[EXT_COUNT-1:0];
        default:       ;
      endcase
    end
  end

  // Pin selectors, four to a word, one byte lane each.
  // pin selector registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < EXT_COUNT; i++)
        sel[i] <= RST_SEL;
    end
    else if (reg_wr)
    begin
      for (int w = 0; w < SEL_WORDS; w++)
      begin
        if (reg_addr == OFF_SEL0 + 8'(4 * w))
        begin
          for (int k = 0; k < SEL_PER_WORD; k++)
            sel[SEL_PER_WORD * w + k] <= reg_wdata[SEL_LANE * k +: SEL_W];
        end
      end
    end
  end

  // Write-one-to-clear strobes for the pending bits; a zero leaves a bit alone.
  // clear decode
  always_comb
  begin
    clr_vec = '0;
    if (reg_wr && reg_addr == OFF_CLR_LO)
      clr_vec[DATA_W-1:0] = reg_wdata;
    if (reg_wr && reg_addr == OFF_CLR_HI)
      clr_vec[LINE_COUNT-1:DATA_W] = reg_wdata[HI_W-1:0];
  end

  // Read data stand in the cycle after the strobe only; unmapped words read zero.
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFF_IRQ_EN_LO: reg_rdata <= irq_en[DATA_W-1:0];
        OFF_IRQ_EN_HI: reg_rdata <= {{(DATA_W-HI_W){1'b0}}, irq_en[LINE_COUNT-1:DATA_W]};
        OFF_EVT_EN_LO: reg_rdata <= evt_en[DATA_W-1:0];
        OFF_EVT_EN_HI: reg_rdata <= {{(DATA_W-HI_W){1'b0}}, evt_en[LINE_COUNT-1:DATA_W]};
        OFF_RISE_EN:   reg_rdata <= {{(DATA_W-EXT_COUNT){1'b0}}, rise_en};
        OFF_FALL_EN:   reg_rdata <= {{(DATA_W-EXT_COUNT){1'b0}}, fall_en};
        OFF_PEND_LO:   reg_rdata <= pend[DATA_W-1:0];
        OFF_PEND_HI:   reg_rdata <= {{(DATA_W-HI_W){1'b0}}, pend[LINE_COUNT-1:DATA_W]};
        default:
        begin
          reg_rdata <= '0;
          for (int w = 0; w < SEL_WORDS; w++)
          begin
            if (reg_addr == OFF_SEL0 + 8'(4 * w))
            begin
              for (int k = 0; k < SEL_PER_WORD; k++)
                reg_rdata[SEL_LANE * k +: SEL_LANE] <= {1'b0, sel[SEL_PER_WORD * w + k]};
            end
          end
        end
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // External lines: the selected pin clocks two toggle flops, one per edge, so a pulse
  // narrower than a system clock still leaves a mark. The toggles cross by three flops.
  for (genvar i = 0; i < EXT_COUNT; i++)
  begin : g_ext
    logic       rise_tog;
    logic       fall_tog;
    logic [2:0] rise_s;
    logic [2:0] fall_s;
    logic       rise_acc;
    logic       fall_acc;

    assign pin_sel[i] = (sel[i] < SEL_W'(PIN_COUNT)) ? gpio_in[sel[i]] : 1'b0;

    always_ff @(posedge pin_sel[i] or posedge sys_rst)
    begin
      if (sys_rst)
        rise_tog <= 1'b0;
      else
        rise_tog <= ~rise_tog;
    end

    always_ff @(negedge pin_sel[i] or posedge sys_rst)
    begin
      if (sys_rst)
        fall_tog <= 1'b0;
      else
        fall_tog <= ~fall_tog;
    end

    // A change counts once the second and third stages agree.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        rise_s   <= '0;
        fall_s   <= '0;
        rise_acc <= 1'b0;
        fall_acc <= 1'b0;
      end
      else
      begin
        rise_s <= {rise_s[1:0], rise_tog};
        fall_s <= {fall_s[1:0], fall_tog};
        if (rise_s[1] == rise_s[2])
          rise_acc <= rise_s[2];
        if (fall_s[1] == fall_s[2])
          fall_acc <= fall_s[2];
      end
    end

    assign rise_hit[i] = (rise_s[1] == rise_s[2]) && (rise_s[2] != rise_acc);
    assign fall_hit[i] = (fall_s[1] == fall_s[2]) && (fall_s[2] != fall_acc);
    assign hit[i] = (rise_hit[i] && rise_en[i]) || (fall_hit[i] && fall_en[i]);

    sequence s_new_rise;
      (rise_s[1] == rise_s[2]) && (rise_s[2] != rise_acc);
    endsequence
    property p_ext_capture;
      @(posedge sys_clk) disable iff (sys_rst)
      s_new_rise ##0 rise_en[i] |-> hit[i] ##1 !rise_hit[i];
    endproperty
    a_ext_capture: assert property (p_ext_capture)
      else $error("Captured rising edge not taken exactly once.");
  end

  // Internal lines are same-clock wakeup sources; a rising level counts as one request.
  // peripheral lines
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      periph_q <= '0;
    else
      periph_q <= periph_wake_in;
  end

  assign hit[LINE_COUNT-1:EXT_COUNT] = periph_wake_in & ~periph_q;

  // Pending: set only for unmasked lines, and a set in the clearing cycle wins.
  // mask gates pending
  assign next_pend = (pend & ~clr_vec) | (hit & irq_en);

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pend <= '0;
    else
      pend <= next_pend;
  end

  // Per-line requests toward the processor and the combined level.
  // request outputs
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      line_irq <= '0;
      irq      <= 1'b0;
      evt_req  <= 1'b0;
    end
    else
    begin
      line_irq <= next_pend & irq_en;
      irq      <= |(next_pend & irq_en);
      evt_req  <= |(hit & evt_en);
    end
  end

  // Wakeup stays up while an enabled request is pending, so a slow power
  // controller cannot miss it; an event line gives a one-cycle wake.
  // stop wakeup
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wakeup_req <= 1'b0;
    else
      wakeup_req <= stop_mode && ((|(next_pend & irq_en)) || (|(hit & evt_en)));
  end

  property p_pend_set;
    @(posedge sys_clk) disable iff (sys_rst)
    (hit & irq_en) != '0 |=> (pend & $past(hit & irq_en)) == $past(hit & irq_en);
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("Unmasked hit did not set pending.");

  property p_mask;
    @(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> (pend & ~$past(pend) & ~$past(irq_en)) == '0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("Masked line set pending.");

  property p_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> ($past(pend) & ~$past(clr_vec) & ~pend) == '0;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Pending bit fell without a clear.");

  property p_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    (clr_vec & ~hit) != '0 |=> (pend & $past(clr_vec & ~hit)) == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Write of one did not clear pending.");

  property p_irq;
    @(posedge sys_clk) disable iff (sys_rst)
    irq == (line_irq != '0) && line_irq == (pend & $past(irq_en));
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt outputs disagree with pending and mask.");

  property p_evt;
    @(posedge sys_clk) disable iff (sys_rst)
    evt_req == $past((hit & evt_en) != '0);
  endproperty
  a_evt: assert property (p_evt)
    else $error("Event request not one cycle after enabled hit.");

  property p_wake;
    @(posedge sys_clk) disable iff (sys_rst)
    stop_mode && (hit & (irq_en | evt_en)) != '0 |=> wakeup_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Enabled edge in Stop did not wake.");

  property p_edge_sel;
    @(posedge sys_clk) disable iff (sys_rst)
    (hit[EXT_COUNT-1:0] & ~(rise_en | fall_en)) == '0;
  endproperty
  a_edge_sel: assert property (p_edge_sel)
    else $error("External hit without its chosen edge.");

  property p_periph;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(periph_wake_in[0]) && irq_en[EXT_COUNT] |=> pend[EXT_COUNT];
  endproperty
  a_periph: assert property (p_periph)
    else $error("Peripheral wake did not set its pending bit.");

  property p_sel;
    @(posedge sys_clk) disable iff (sys_rst)
    sel[0] < SEL_W'(PIN_COUNT) |-> pin_sel[0] == gpio_in[sel[0]];
  endproperty
  a_sel: assert property (p_sel)
    else $error("Line 0 not fed by its selected pin.");

  property p_rdata;
    @(posedge sys_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("Read data outside the answer cycle.");

endmodule

/* dv/pin_wake_source.sv */
// Partner model: the general-purpose pins and the wakeup-capable peripherals.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps

module pin_wake_source
  import edge_wakeup_pkg::*;
(
  input  wire logic                                  sys_clk,
  output logic      [edge_wakeup_pkg::PIN_COUNT-1:0] gpio_in,
  output logic      [edge_wakeup_pkg::INT_COUNT-1:0] periph_wake_in
);
  // Pins and peripheral wake levels idle low.
  initial
  begin
    gpio_in = '0;
    periph_wake_in = '0;
  end

  // Moves one pin to a new level just after an edge.
  task pin_set(input int idx, input logic val);
    @(posedge sys_clk);
    gpio_in[idx] <= val;
  endtask

  // A 1 ns pulse, far shorter than the 4 ns clock, so only edge capture can see it.
  task pin_pulse(input int idx);
    pin_set(idx, 1'b1);
    #1 gpio_in[idx] <= 1'b0;
  endtask

  // One-cycle wake level from a peripheral; the rise is the request.
  task wake_rise(input int idx);
    @(posedge sys_clk);
    periph_wake_in[idx] <= 1'b1;
    @(posedge sys_clk);
    periph_wake_in[idx] <= 1'b0;
  endtask
endmodule

/* dv/edge_event_wakeup_controller_tb.sv */
// Self-checking bench for the edge event and wakeup controller.
// Assumes the pin and peripheral model in pin_wake_source drives the far side.
`timescale 1ns/1ps

module edge_event_wakeup_controller_tb;
  import edge_wakeup_pkg::*;

  logic                  sys_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic [ADDR_W-1:0]     reg_addr = '0;
  logic [DATA_W-1:0]     reg_wdata = '0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [DATA_W-1:0]     reg_rdata;
  logic [PIN_COUNT-1:0]  gpio_in;
  logic [INT_COUNT-1:0]  periph_wake_in;
  logic                  stop_mode = 1'b0;
  logic [LINE_COUNT-1:0] line_irq;
  logic                  irq;
  logic                  evt_req;
  logic                  wakeup_req;
  int                    err_count = 0;
  int                    cmp_count = 0;
  int                    cycles = 0;
  logic [DATA_W-1:0]     rdat;

  edge_event_wakeup_controller DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio_in),
    .periph_wake_in(periph_wake_in), .stop_mode(stop_mode), .line_irq(line_irq), .irq(irq),
    .evt_req(evt_req), .wakeup_req(wakeup_req));

  pin_wake_source m (.sys_clk(sys_clk), .gpio_in(gpio_in), .periph_wake_in(periph_wake_in));

  // Clock at 250 MHz.
  always #2 sys_clk = ~sys_clk;

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      conclude();
    end
  end

  task conclude();
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string name, input logic [43:0] exp, input logic [43:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rdat = reg_rdata;
  endtask

  task settle();
    repeat (8) @(posedge sys_clk);
    #1;
  endtask

  task t_reset_regs();
    rd(OFF_IRQ_EN_LO);
    chk("irq_en_lo", 44'h0, {12'h0, rdat});
    rd(8'h28);
    chk("unmapped", 44'h0, {12'h0, rdat});
    rd(OFF_PEND_HI);
    chk("pend_hi", 44'h0, {12'h0, rdat});
  endtask

  // Line 0 fed from the last pin by a sub-clock pulse; pending holds until a one is written.
  task t_rise_short();
    wr(OFF_SEL0, 32'h0000_006a);
    wr(OFF_RISE_EN, 32'h1);
    wr(OFF_IRQ_EN_LO, 32'h1);
    m.pin_pulse(106);
    settle();
    chk("irq", 44'h1, {43'h0, irq});
    chk("line_irq", 44'h1, line_irq);
    // Outside Stop a pending request must not raise a wakeup.
    chk("wake_off", 44'h0, {43'h0, wakeup_req});
    wr(OFF_CLR_LO, 32'h0);
    rd(OFF_PEND_LO);
    chk("pend_keep", 44'h1, {12'h0, rdat});
    wr(OFF_CLR_LO, 32'h1);
    rd(OFF_PEND_LO);
    chk("pend_clr", 44'h0, {12'h0, rdat});
  endtask

  // Line 1 on falling edges only, then on both; line 2 stays masked.
  task t_edge_mask();
    wr(OFF_SEL0, 32'h0007_056a);
    wr(OFF_FALL_EN, 32'h2);
    wr(OFF_RISE_EN, 32'h5);
    wr(OFF_IRQ_EN_LO, 32'h3);
    m.pin_set(5, 1'b1);
    m.pin_pulse(7);
    settle();
    chk("rise_ignored", 44'h0, line_irq);
    m.pin_set(5, 1'b0);
    settle();
    chk("fall_hit", 44'h2, line_irq);
    rd(OFF_PEND_LO);
    chk("masked_pend", 44'h2, {12'h0, rdat});
    // Each selector byte reads back with its top bit zero.
    rd(OFF_SEL0);
    chk("sel_word", 44'h0007_056a, {12'h0, rdat});
    wr(OFF_CLR_LO, 32'h2);
    wr(OFF_RISE_EN, 32'h3);
    m.pin_set(5, 1'b1);
    settle();
    chk("both_rise", 44'h2, line_irq);
    wr(OFF_CLR_LO, 32'h2);
  endtask

  // Peripheral lines 16 and 43 during Stop: one event pulse, pending, and a wakeup.
  task t_internal();
    int n;
    n = 0;
    wr(OFF_EVT_EN_LO, 32'h0001_0000);
    wr(OFF_IRQ_EN_HI, 32'h800);
    stop_mode <= 1'b1;
    m.wake_rise(0);
    // The event pulse stands in the cycle right after the rise, so counting starts there.
    #1 n = int'(evt_req === 1'b1);
    repeat (5)
    begin
      @(posedge sys_clk);
      #1 n += int'(evt_req === 1'b1);
    end
    chk("evt_pulses", 44'h1, 44'(n));
    chk("no_wake", 44'h0, {43'h0, wakeup_req});
    m.wake_rise(27);
    settle();
    chk("wake", 44'h1, {43'h0, wakeup_req});
    rd(OFF_PEND_HI);
    chk("pend_hi", 44'h800, {12'h0, rdat});
    wr(OFF_CLR_HI, 32'h800);
    stop_mode <= 1'b0;
    settle();
    chk("irq_off", 44'h0, {43'h0, irq});
  endtask

  // Main sequence.
  initial
  begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset_regs();
    t_rise_short();
    t_edge_mask();
    t_internal();
    conclude();
  end
endmodule
